// file: hdl/gate_input_command_logic.sv
// command and safety input logic for a sliding gate motor controller
// Functional notes
// [RULE_01] a momentary open input drives the gate toward fully open
// [RULE_02] held open input ignores mid-travel stop and pauses auto-close
// [RULE_03] station open, close and stop contacts each command travel
// [RULE_04] opening edge sensor while moving: halt, back off briefly, halt
// [RULE_05] after that, auto-close off and gate waits for a fresh command
// [RULE_06] opening edge again before a limit: stop, lockout, alarm
// [RULE_07] closing edge sensor while moving: halt, reverse to fully open; the code reverses only while closing, not while opening or backing off
// [RULE_08] opening fault during that reversal: lockout with alarm
// [RULE_09] auto-close starts closing after timer once closing edge clears
// [RULE_10] back-to-open request while closing reverses to fully open
// [RULE_11] exit loop opens gate and holds it open while triggered
// [RULE_12] reverse loop while closing reverses to fully open
// [RULE_13] every contact is synchronised and debounced to one clean event; limits and strap are only synchronised
// [RULE_14] lockout holds until reset; commands cannot move the gate
`timescale 1ns/1ps
module gate_input_command_logic
    import gate_cmd_pkg::*;
#(
    parameter logic [DB_W-1:0]  DB_CYC        = DB_W'(DEBOUNCE_CYC),
    parameter logic [TMR_W-1:0] BACKOFF_CYC   = TMR_W'(BACKOFF_CYC_DEF),
    parameter logic [TMR_W-1:0] AUTOCLOSE_CYC = TMR_W'(AUTOCLOSE_CYC_DEF)
)
(
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic open_in,
    input  wire logic station_open,
    input  wire logic station_close,
    input  wire logic station_stop,
    input  wire logic opening_edge_sensor,
    input  wire logic closing_edge_sensor,
    input  wire logic back_to_open_request,
    input  wire logic exit_loop,
    input  wire logic reverse_loop,
    input  wire logic open_entrapment,
    input  wire logic open_limit,
    input  wire logic close_limit,
    input  wire logic autoclose_enable,
    output logic      motor_open,
    output logic      motor_close,
    output logic      lockout,
    output logic      alarm_tone,
    output logic      autoclose_disabled
);
    logic [N_IN-1:0]  raw;
    logic [N_IN-1:0]  lvl;
    logic [N_IN-1:0]  rise;
    logic             lim_o1_r;
    logic             lim_o2_r;
    logic             lim_c1_r;
    logic             lim_c2_r;
    logic             ac_en1_r;
    logic             ac_en2_r;

    gate_state_e      st_r;
    gate_state_e      st_nxt;
    logic [TMR_W-1:0] tmr_r;
    logic [TMR_W-1:0] tmr_nxt;
    logic             strike_r;
    logic             strike_nxt;
    logic             rev_open_r;
    logic             rev_open_nxt;
    logic             ac_off_r;
    logic             ac_off_nxt;
    logic             mo_r;
    logic             mc_r;
    logic             lk_r;
    logic             al_r;
    logic             ad_r;
    // back off runs against the travel that was interrupted
    logic             bk_open_r;
    logic             bk_open_nxt;
    logic             mo_nxt;
    logic             mc_nxt;
    logic             lk_nxt;
    logic             al_nxt;
    logic             ad_nxt;

    assign raw = {open_entrapment, reverse_loop, exit_loop,
                  back_to_open_request, closing_edge_sensor,
                  opening_edge_sensor, station_stop, station_close,
                  station_open, open_in};

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_in
            contact_debounce #(
                .DB_CYC    (DB_CYC)
            ) u_db ( // RULE_13
                .clk_sys   (clk_sys),
                .resetn    (resetn),
                .ce        (ce),
                .raw_in    (raw[gi]),
                .level_out (lvl[gi]),
                .rise_out  (rise[gi])
            );
        end
    endgenerate

    // limit switches and the strap only need two-stage synchronising
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            lim_o1_r <= 1'b0;
            lim_o2_r <= 1'b0;
            lim_c1_r <= 1'b0;
            lim_c2_r <= 1'b0;
            ac_en1_r <= 1'b0;
            ac_en2_r <= 1'b0;
        end else if (ce) begin
            lim_o1_r <= open_limit;
            lim_o2_r <= lim_o1_r;
            lim_c1_r <= close_limit;
            lim_c2_r <= lim_c1_r;
            ac_en1_r <= autoclose_enable;
            ac_en2_r <= ac_en1_r;
        end
    end

    logic open_cmd;
    logic close_cmd;
    logic stop_cmd;
    logic hold_open;
    logic reverse_req;
    logic open_fault;

    always_comb begin
        open_cmd    = rise[IN_OPEN] | rise[IN_ST_OPEN]
                    | rise[IN_EXIT_LOOP]; // RULE_01 RULE_03 RULE_11
        close_cmd   = rise[IN_ST_CLOSE]; // RULE_03
        hold_open   = lvl[IN_OPEN] | lvl[IN_ST_OPEN]
                    | lvl[IN_EXIT_LOOP]; // RULE_02 RULE_11
        stop_cmd    = rise[IN_ST_STOP] & ~hold_open; // RULE_02 RULE_03
        reverse_req = rise[IN_BACK_OPEN] | rise[IN_REV_LOOP]
                    | rise[IN_CLOSE_EDGE]; // RULE_07 RULE_10 RULE_12
        open_fault  = rise[IN_OPEN_EDGE] | rise[IN_ENTRAP];
    end

    always_comb begin
        st_nxt       = st_r;
        tmr_nxt      = tmr_r;
        strike_nxt   = strike_r;
        rev_open_nxt = rev_open_r;
        ac_off_nxt   = ac_off_r;
        bk_open_nxt  = bk_open_r;
        case (st_r)
            ST_IDLE, ST_HELD: begin
                if (open_cmd && !lim_o2_r) begin
                    st_nxt       = ST_OPENING;
                    rev_open_nxt = 1'b0;
                    ac_off_nxt   = 1'b0; // RULE_05
                end else if (close_cmd && !lim_c2_r && !hold_open) begin
                    st_nxt     = ST_CLOSING;
                    ac_off_nxt = 1'b0; // RULE_05
                end else if (lim_o2_r && ac_en2_r && !ac_off_r
                             && st_r == ST_IDLE) begin
                    // timer runs only with no hold and the closing edge clear
                    if (hold_open || lvl[IN_CLOSE_EDGE]) begin
                        tmr_nxt = '0; // RULE_02 RULE_09
                    end else if (tmr_r >= AUTOCLOSE_CYC - 1) begin
                        tmr_nxt = '0;
                        st_nxt  = ST_CLOSING; // RULE_09
                    end else begin
                        tmr_nxt = tmr_r + TMR_W'(1);
                    end
                end else begin
                    tmr_nxt = '0;
                end
            end
            ST_OPENING: begin
                tmr_nxt = '0;
                if (open_fault && (strike_r || rev_open_r)) begin
                    st_nxt = ST_LOCKOUT; // RULE_06 RULE_08
                end else if (rise[IN_OPEN_EDGE]) begin
                    st_nxt      = ST_BACKOFF; // RULE_04
                    strike_nxt  = 1'b1;
                    bk_open_nxt = 1'b0; // RULE_04
                    ac_off_nxt  = 1'b1; // RULE_05
                end else if (lim_o2_r) begin
                    st_nxt       = ST_IDLE;
                    strike_nxt   = 1'b0;
                    rev_open_nxt = 1'b0;
                end else if (stop_cmd) begin
                    st_nxt = ST_IDLE; // RULE_03
                end
            end
            ST_CLOSING: begin
                tmr_nxt = '0;
                if (reverse_req || open_cmd) begin
                    st_nxt       = ST_OPENING; // RULE_07 RULE_10 RULE_12
                    rev_open_nxt = reverse_req;
                end else if (rise[IN_OPEN_EDGE]) begin
                    if (strike_r) begin
                        st_nxt = ST_LOCKOUT; // RULE_06
                    end else begin
                        st_nxt      = ST_BACKOFF; // RULE_04
                        strike_nxt  = 1'b1;
                        bk_open_nxt = 1'b1; // RULE_04
                        ac_off_nxt  = 1'b1; // RULE_05
                    end
                end else if (lim_c2_r) begin
                    st_nxt     = ST_IDLE;
                    strike_nxt = 1'b0;
                end else if (stop_cmd) begin
                    st_nxt = ST_IDLE;
                end
            end
            ST_BACKOFF: begin
                // short drive against the travel, cut short at a limit
                if (tmr_r >= BACKOFF_CYC - 1
                    || (bk_open_r ? lim_o2_r : lim_c2_r)) begin
                    tmr_nxt = '0;
                    st_nxt  = ST_HELD; // RULE_04 RULE_05
                end else begin
                    tmr_nxt = tmr_r + TMR_W'(1);
                end
            end
            ST_LOCKOUT: begin
                st_nxt = ST_LOCKOUT; // RULE_14
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    // output drives follow the next state so each leaves a flip-flop
    always_comb begin
        mo_nxt = (st_nxt == ST_OPENING)
               || (st_nxt == ST_BACKOFF && bk_open_nxt); // RULE_04
        mc_nxt = (st_nxt == ST_CLOSING)
               || (st_nxt == ST_BACKOFF && !bk_open_nxt); // RULE_04
        lk_nxt = (st_nxt == ST_LOCKOUT); // RULE_14
        al_nxt = (st_nxt == ST_LOCKOUT); // RULE_06 RULE_08
        ad_nxt = ac_off_nxt; // RULE_05
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            st_r       <= ST_IDLE;
            tmr_r      <= '0;
            strike_r   <= 1'b0;
            rev_open_r <= 1'b0;
            ac_off_r   <= 1'b0;
            bk_open_r  <= 1'b0;
            mo_r       <= 1'b0;
            mc_r       <= 1'b0;
            lk_r       <= 1'b0;
            al_r       <= 1'b0;
            ad_r       <= 1'b0;
        end else if (ce) begin
            st_r       <= st_nxt;
            tmr_r      <= tmr_nxt;
            strike_r   <= strike_nxt;
            rev_open_r <= rev_open_nxt;
            ac_off_r   <= ac_off_nxt;
            bk_open_r  <= bk_open_nxt;
            mo_r       <= mo_nxt;
            mc_r       <= mc_nxt;
            lk_r       <= lk_nxt;
            al_r       <= al_nxt;
            ad_r       <= ad_nxt;
        end
    end

    assign motor_open         = mo_r;
    assign motor_close        = mc_r;
    assign lockout            = lk_r;
    assign alarm_tone         = al_r;
    assign autoclose_disabled = ad_r;
endmodule // gate_input_command_logic

// file: shared/gate_cmd_pkg.sv
// constants and types shared by the gate command logic
package gate_cmd_pkg;
    localparam int          CLK_HZ          = 125_000_000;
    localparam int          DEBOUNCE_US     = 10_000;
    localparam int          DEBOUNCE_CYC    =
        (DEBOUNCE_US / 1000) * (CLK_HZ / 1000);
    localparam int          DB_W            = 21;
    localparam int          BACKOFF_MS      = 500;
    localparam int          BACKOFF_CYC_DEF = BACKOFF_MS * (CLK_HZ / 1000);
    localparam int          AUTOCLOSE_S     = 30;
    localparam int          AUTOCLOSE_CYC_DEF = AUTOCLOSE_S * CLK_HZ;
    localparam int          TMR_W           = 32;
    localparam int          N_IN            = 10;
    localparam int          IN_OPEN         = 0;
    localparam int          IN_ST_OPEN      = 1;
    localparam int          IN_ST_CLOSE     = 2;
    localparam int          IN_ST_STOP      = 3;
    localparam int          IN_OPEN_EDGE    = 4;
    localparam int          IN_CLOSE_EDGE   = 5;
    localparam int          IN_BACK_OPEN    = 6;
    localparam int          IN_EXIT_LOOP    = 7;
    localparam int          IN_REV_LOOP     = 8;
    localparam int          IN_ENTRAP       = 9;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPENING,
        ST_CLOSING,
        ST_BACKOFF,
        ST_HELD,
        ST_LOCKOUT
    } gate_state_e;
endpackage

// file: hdl/contact_debounce.sv
// synchroniser and debouncer for one contact input
`timescale 1ns/1ps
module contact_debounce
    import gate_cmd_pkg::*;
#(
    parameter logic [DB_W-1:0] DB_CYC = DB_W'(DEBOUNCE_CYC)
)
(
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic ce,
    input  wire logic raw_in,
    output logic      level_out,
    output logic      rise_out
);
    logic              s1_r;
    logic              s2_r;
    logic              lvl_r;
    logic              lvl_nxt;
    logic              rise_r;
    logic              rise_nxt;
    logic [DB_W-1:0]   cnt_r;
    logic [DB_W-1:0]   cnt_nxt;

    always_comb begin
        lvl_nxt  = lvl_r;
        rise_nxt = 1'b0;
        cnt_nxt  = cnt_r;
        if (s2_r == lvl_r) begin
            cnt_nxt = '0;
        end else if (cnt_r == DB_CYC - DB_W'(1)) begin
            cnt_nxt  = '0;
            lvl_nxt  = s2_r;
            rise_nxt = s2_r;
        end else begin
            cnt_nxt = cnt_r + DB_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s1_r   <= 1'b0;
            s2_r   <= 1'b0;
            lvl_r  <= 1'b0;
            rise_r <= 1'b0;
            cnt_r  <= '0;
        end else if (ce) begin
            s1_r   <= raw_in;
            s2_r   <= s1_r;
            lvl_r  <= lvl_nxt;
            rise_r <= rise_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    assign level_out = lvl_r;
    assign rise_out  = rise_r;
endmodule // contact_debounce

// file: verif/gate_cmd_chk.sv
// port assertions for the gate command logic
`timescale 1ns/1ps
module gate_cmd_chk
    import gate_cmd_pkg::*;
#(
    parameter logic [TMR_W-1:0] BACKOFF_CYC   = 32'h0000_0010,
    parameter logic [TMR_W-1:0] AUTOCLOSE_CYC = 32'h0000_0040
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic ce,
    input wire logic open_in,
    input wire logic station_open,
    input wire logic station_close,
    input wire logic station_stop,
    input wire logic opening_edge_sensor,
    input wire logic closing_edge_sensor,
    input wire logic back_to_open_request,
    input wire logic exit_loop,
    input wire logic reverse_loop,
    input wire logic open_entrapment,
    input wire logic open_limit,
    input wire logic close_limit,
    input wire logic autoclose_enable,
    input wire logic motor_open,
    input wire logic motor_close,
    input wire logic lockout,
    input wire logic alarm_tone,
    input wire logic autoclose_disabled
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    out_reset_a: assert property ($rose(resetn) |-> !(motor_open ||
        motor_close || lockout || alarm_tone || autoclose_disabled))
        else $error("outputs not clear after reset");
    lock_hold_a: assert property (lockout |=> lockout)
        else $error("lockout released");
    lock_still_a: assert property (lockout |-> !motor_open && !motor_close)
        else $error("motor runs in lockout");
    alarm_eq_a: assert property (alarm_tone == lockout)
        else $error("alarm differs from lockout");
    dir_excl_a: assert property (!(motor_open && motor_close))
        else $error("both motor directions on");
    open_stop_a: assert property ((ce && open_limit) [*5] |-> !motor_open)
        else $error("motor opens past open limit");
    open_cause_a: assert property ($rose(motor_open) |-> $past(open_in ||
        station_open || back_to_open_request || closing_edge_sensor ||
        opening_edge_sensor || exit_loop || reverse_loop, 4))
        else $error("open without input");
    lock_cause_a: assert property ($rose(lockout) |->
        $past(opening_edge_sensor || open_entrapment, 4))
        else $error("lockout without opening fault");
    acd_halt_a: assert property ($rose(autoclose_disabled) |->
        motor_open != motor_close) else $error("no back off move");
    cover property ($rose(lockout));
    cover property ($rose(autoclose_disabled));
    cover property ($fell(motor_open) && open_limit);
endmodule // gate_cmd_chk

bind gate_input_command_logic gate_cmd_chk #(
    .BACKOFF_CYC   (BACKOFF_CYC),
    .AUTOCLOSE_CYC (AUTOCLOSE_CYC)
) chk_u (.*);

// file: verif/gate_travel_model.sv
// gate travel model that drives the two limit contacts
`timescale 1ns/1ps
module gate_travel_model
    import gate_cmd_pkg::*;
#(
    parameter int POS_START = DEBOUNCE_CYC / 2,
    parameter int POS_MAX   = 5 * DEBOUNCE_CYC
)
(
    input  wire logic clk_sys,
    input  wire logic motor_open,
    input  wire logic motor_close,
    output logic      open_limit,
    output logic      close_limit
);
    int pos = POS_START;
    // one position a clock, so travel outlasts a debounce interval
    always @(posedge clk_sys) begin
        if (motor_open && pos < POS_MAX) begin
            pos <= pos + 1;
        end else if (motor_close && pos > 0) begin
            pos <= pos - 1;
        end
    end
    assign open_limit  = (pos >= POS_MAX);
    assign close_limit = (pos <= 0);
endmodule // gate_travel_model

// file: verif/gate_input_command_logic_bench.sv
// self-checking bench for the gate command logic
`timescale 1ns/1ps
module gate_input_command_logic_bench
    import gate_cmd_pkg::*;
;
    localparam int DB = 16;
    localparam int W  = DB + 8;
    localparam int L  = 4 * W;
    typedef struct {
        logic [3:0] rel;
        logic [3:0] prs;
        int         w;
        logic [3:0] e;
        logic [3:0] m;
    } row_s;
    logic            clk_sys = 1'b0;
    logic            resetn  = 1'b0;
    logic [N_IN-1:0] cmd     = '0;
    logic            ac_en   = 1'b1;
    logic            open_limit;
    logic            close_limit;
    logic            motor_open;
    logic            motor_close;
    logic            lockout;
    logic            alarm_tone;
    logic            autoclose_disabled;
    int              error_cnt = 0;
    int              compares  = 0;
    wire  [3:0]      outs = {motor_open, motor_close, lockout,
                             autoclose_disabled};
    wire  [3:0]      alm  = {3'h0, alarm_tone};
    // rel: input released first, prs: input pressed (a = reset, f = none)
    row_s            rows [33] = '{
        '{4'hf, 4'h1, W, 4'h8, 4'hf},
        '{4'h1, 4'h3, W, 4'h0, 4'hf},
        '{4'h3, 4'h2, W, 4'h4, 4'hf},
        '{4'h2, 4'h6, W, 4'h8, 4'hf},
        '{4'h6, 4'h3, W, 4'h0, 4'hf},
        '{4'h3, 4'h2, W, 4'h4, 4'hf},
        '{4'h2, 4'h8, W, 4'h8, 4'hf},
        '{4'h8, 4'h3, W, 4'h0, 4'hf},
        '{4'h3, 4'h2, W, 4'h4, 4'hf},
        '{4'h2, 4'h5, W, 4'h8, 4'hf},
        '{4'h5, 4'h4, W, 4'h2, 4'he},
        '{4'h4, 4'h1, W, 4'h2, 4'he},
        '{4'h1, 4'ha, 2, 4'h0, 4'hf},
        '{4'hf, 4'h0, W, 4'h8, 4'hf},
        '{4'h0, 4'h4, W, 4'h4, 4'he},
        '{4'hf, 4'hf, 40, 4'h1, 4'hf},
        '{4'h4, 4'hf, W, 4'h1, 4'hf},
        '{4'hf, 4'h0, W, 4'h8, 4'he},
        '{4'h0, 4'h4, W, 4'h2, 4'he},
        '{4'h4, 4'ha, 2, 4'h0, 4'hf},
        '{4'hf, 4'h0, W, 4'h8, 4'hf},
        '{4'hf, 4'h3, W, 4'h8, 4'hf},
        '{4'h3, 4'hf, L, 4'h0, 4'hf},
        '{4'h0, 4'hf, L, 4'h4, 4'hf},
        '{4'hf, 4'h5, W, 4'h8, 4'hf},
        '{4'hf, 4'hf, L, 4'h0, 4'hf},
        '{4'h5, 4'hf, L, 4'h4, 4'hf},
        '{4'hf, 4'h7, W, 4'h8, 4'hf},
        '{4'hf, 4'hf, L, 4'h0, 4'hf},
        '{4'h7, 4'hf, L, 4'h4, 4'hf},
        '{4'hf, 4'h5, W, 4'h8, 4'hf},
        '{4'hf, 4'h9, W, 4'h2, 4'he},
        '{4'h9, 4'ha, 2, 4'h0, 4'hf}
    };

    always #4 clk_sys = ~clk_sys;

    gate_input_command_logic #(
        .DB_CYC        (DB_W'(DB)),
        .BACKOFF_CYC   (32'h0000_0010),
        .AUTOCLOSE_CYC (32'h0000_0040)
    ) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .ce(1'b1),
        .open_in(cmd[IN_OPEN]), .station_open(cmd[IN_ST_OPEN]),
        .station_close(cmd[IN_ST_CLOSE]), .station_stop(cmd[IN_ST_STOP]),
        .opening_edge_sensor(cmd[IN_OPEN_EDGE]),
        .closing_edge_sensor(cmd[IN_CLOSE_EDGE]),
        .back_to_open_request(cmd[IN_BACK_OPEN]),
        .exit_loop(cmd[IN_EXIT_LOOP]), .reverse_loop(cmd[IN_REV_LOOP]),
        .open_entrapment(cmd[IN_ENTRAP]), .open_limit(open_limit),
        .close_limit(close_limit), .autoclose_enable(ac_en),
        .motor_open(motor_open), .motor_close(motor_close),
        .lockout(lockout), .alarm_tone(alarm_tone),
        .autoclose_disabled(autoclose_disabled)
    );

    gate_travel_model #(
        .POS_START (200),
        .POS_MAX   (400)
    ) gate_u (
        .clk_sys(clk_sys), .motor_open(motor_open),
        .motor_close(motor_close), .open_limit(open_limit),
        .close_limit(close_limit)
    );

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic chk(input string nm, input logic [3:0] exp,
                       input logic [3:0] got, input logic [3:0] msk);
        compares++;
        if ((got & msk) !== (exp & msk)) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp & msk,
                     got & msk);
        end
    endtask

    task automatic summarize();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        cyc(16);
        resetn = 1'b1;
        chk("reset", 4'h0, outs, 4'hf);
        foreach (rows[i]) begin
            if (rows[i].rel != 4'hf) begin
                cmd[rows[i].rel] = 1'b0;
                cyc(W);
            end
            if (rows[i].prs == 4'ha) begin
                resetn = 1'b0;
                cyc(16);
                resetn = 1'b1;
            end else if (rows[i].prs != 4'hf) begin
                cmd[rows[i].prs] = 1'b1;
            end
            cyc(rows[i].w);
            chk($sformatf("row %0d", i), rows[i].e, outs, rows[i].m);
            chk("alarm", {3'h0, rows[i].e[1]}, alm, 4'h1);
        end
        // auto-close strap low: the gate must stay at the open limit
        ac_en = 1'b0;
        cmd   = '0;
        cyc(W);
        cmd[IN_OPEN] = 1'b1;
        cyc(L);
        cmd[IN_OPEN] = 1'b0;
        cyc(2 * L);
        chk("no autoclose", 4'h0, outs, 4'hf);
        ac_en = 1'b1;
        cyc(L);
        chk("autoclose", 4'h4, outs, 4'hf);
        // opening edge while closing backs the gate off toward open
        cmd[IN_OPEN_EDGE] = 1'b1;
        cyc(W);
        chk("close backoff", 4'h8, outs, 4'he);
        cyc(40);
        chk("close held", 4'h1, outs, 4'hf);
        resetn = 1'b0;
        cyc(16);
        resetn = 1'b1;
        cyc(1);
        chk("mid reset", 4'h0, outs, 4'hf);
        summarize();
    end

    initial begin
        cyc(300 * W);
        error_cnt++;
        summarize();
    end
endmodule // gate_input_command_logic_bench
